// File: csiu_cfg.svh
// Constants of the clock status and interrupt unit: register offsets,
// field positions, reset values and synchroniser depth.
// Assumes it is included by bare name from the top-level design file.
//
// What this block does
// [R1] Synthesizer PLL unlock latch with its enable set pulls the interrupt low.
// [R2] Oscillator PLL unlock latch with its enable set pulls the interrupt low.
// [R3] Each input's loss-of-signal latch with its enable set pulls interrupt low.
// [R4] Reference status change in either direction, when enabled, pulls interrupt low.
// [R5] Holdover latch with its enable set pulls the interrupt low.
// [R6] Enables are read/write, reset to 0; disabled sources never assert interrupt.
// [R7] Synthesizer unlock latch reads 0 after any unlock since clear, else 1.
// [R8] Oscillator unlock latch reads 0 after any unlock since clear, else 1.
// [R9] Writing 1 to a PLL unlock latch clears it and its pending interrupt.
// [R10] Each input latch reads 0 after any loss of signal since clear, else 1.
// [R11] Writing 1 to an input latch clears it and its pending interrupt.
// [R12] Two-bit read-only field reports the input the selector currently uses.
// [R13] Each PLL live lock bit reads 0 during unlock and feeds its latch.
// [R14] Each input live activity bit reads 0 on loss of signal, else 1.
// [R15] Reference latch reads 0 if reference lost since clear, else 1.
// [R16] Writing 1 to the reference latch clears it and its pending interrupt.
// [R17] Holdover latch reads 0 after any holdover since clear; write 1 clears.
// [R18] Live reference bit reads 1 when present, 0 when absent; feeds latch.
// [R19] Interrupt output is active-low OR of enabled pending sources, held until cleared.

`ifndef CSIU_CFG_SVH
`define CSIU_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CSIU_ADDR_IRQ_EN_LOCK   8'h68
`define CSIU_ADDR_IRQ_EN_REF    8'h69
`define CSIU_ADDR_LATCHED_LOCK  8'h6c
`define CSIU_ADDR_LIVE_LOCK     8'h6d
`define CSIU_ADDR_LATCHED_REF   8'h6e
`define CSIU_ADDR_LIVE_REF      8'h6f

// ----------------------------------------------------------------------------
// Field positions (source index equals bit position in the lock registers)
// ----------------------------------------------------------------------------
`define CSIU_BIT_SYNTH          5
`define CSIU_BIT_OSC            4
`define CSIU_BIT_INPUT_HI       3
`define CSIU_BIT_SEL_LO         6
`define CSIU_BIT_REF            1
`define CSIU_BIT_HOLD           0
`define CSIU_SRC_HOLD           6

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CSIU_RST_IRQ_EN         8'h00
`define CSIU_RST_RDATA          8'h00
`define CSIU_RST_LIVE           11'h1fe
`define CSIU_RST_REF_PREV       1'b1
`define CSIU_RST_IRQ_N          1'b1
`define CSIU_SYNC_STAGES        2

`endif

// File: csiu_pkg.sv
// Types shared by the clock status and interrupt unit.
// Assumes csiu_cfg.svh is available on the include path.
package csiu_pkg;

  // --------------------------------------------------------------------------
  // Live indicators from the detectors and the input selector.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] selected_input_code;
    logic       synth_pll_lock_live_n;
    logic       osc_pll_lock_live_n;
    logic [3:0] input_active_live;
    logic       reference_present_live;
    logic       holdover_live_n;
    logic       synth_calibration_active;
  } csiu_live_t;

  // --------------------------------------------------------------------------
  // One register access from the serial port decoder.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csiu_reg_req_t;

endpackage : csiu_pkg

// File: csiu_sync.sv
// Two-flop level synchroniser for a group of indicator bits.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/1ps
`default_nettype none
module csiu_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta;

  // -------------------------------------------------------------------------
  // Stages
  // -------------------------------------------------------------------------
  // The first stage feeds only the second, so no logic sees a metastable bit.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      meta     <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : csiu_sync
`default_nettype wire

// File: csiu_sticky.sv
// Bank of sticky event flags with write-one-to-clear.
// Assumes event and clear come from logic on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module csiu_sticky #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] event_in,
  input  wire logic [W-1:0] clear_in,
  output logic      [W-1:0] flag
);

  // -------------------------------------------------------------------------
  // Flags
  // -------------------------------------------------------------------------
  // Set wins over clear, so an event in the clearing cycle is never lost.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      flag <= '0;
    else
      flag <= event_in | (flag & ~clear_in);
  end

endmodule : csiu_sticky
`default_nettype wire

// File: csiu_top.sv
// Status latches, interrupt enables and active-low interrupt output of the
// clock status and interrupt unit.
// Assumes the register decoder drives reg_req on sys_clk and that the live
// indicators come from other clock domains and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "csiu_cfg.svh"
module csiu_top
  import csiu_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire csiu_live_t    live_in,
  input  wire csiu_reg_req_t reg_req,
  output logic [7:0]         reg_rdata,
  output logic               reg_rvalid,
  output logic               irq_out_n
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  csiu_live_t  live_s;          // Synchronised live indicators.
  logic [6:0]  src_event;       // Per-source event level, active high.
  logic [6:0]  src_clear;       // Per-source write-one-to-clear strobe.
  logic [6:0]  src_sticky;      // Per-source latched event.
  logic [6:0]  src_irq_en;      // Per-source interrupt enable.
  logic        reference_change_irq_en;
  logic        ref_prev;        // Reference level one cycle ago.
  logic        ref_edge;        // Reference level changed this cycle.
  logic [1:0]  ref_event;
  logic [1:0]  ref_clear;
  logic [1:0]  ref_sticky;      // [0] reference lost, [1] change pending.
  logic        wr_en_lock;
  logic        wr_en_ref;
  logic        wr_lat_lock;
  logic        wr_lat_ref;
  logic        next_irq_n;
  logic [7:0]  next_rdata;
  logic [7:0]  synth_pll_unlock_sticky_n_v;
  logic        reference_valid_sticky;
  logic        holdover_sticky_n;

  // --------------------------------------------------------------------------
  // Input synchronisation
  // --------------------------------------------------------------------------
  // Reset value is "all healthy", so a clean start raises no latched event.
  csiu_sync #(
    .W       ($bits(csiu_live_t)),
    .RST_VAL (`CSIU_RST_LIVE)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (live_in),
    .sync_out (live_s)
  );

  // --------------------------------------------------------------------------
  // Register write decode
  // --------------------------------------------------------------------------
  // One strobe per writable register; unmapped writes are dropped.
  assign wr_en_lock  = reg_req.wr && (reg_req.addr == `CSIU_ADDR_IRQ_EN_LOCK);
  assign wr_en_ref   = reg_req.wr && (reg_req.addr == `CSIU_ADDR_IRQ_EN_REF);
  assign wr_lat_lock = reg_req.wr && (reg_req.addr == `CSIU_ADDR_LATCHED_LOCK);
  assign wr_lat_ref  = reg_req.wr && (reg_req.addr == `CSIU_ADDR_LATCHED_REF);

  // --------------------------------------------------------------------------
  // Interrupt enables
  // --------------------------------------------------------------------------
  // Both enable registers reset to zero; reserved bits are not stored.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      src_irq_en              <= 7'(`CSIU_RST_IRQ_EN);                      // [R6]
      reference_change_irq_en <= 1'(`CSIU_RST_IRQ_EN);                      // [R6]
    end
    else
    begin
      if (wr_en_lock)
        src_irq_en[5:0] <= reg_req.wdata[5:0];                              // [R6]
      if (wr_en_ref)
      begin
        src_irq_en[`CSIU_SRC_HOLD] <= reg_req.wdata[`CSIU_BIT_HOLD];        // [R6]
        reference_change_irq_en    <= reg_req.wdata[`CSIU_BIT_REF];         // [R6]
      end
    end
  end

  // --------------------------------------------------------------------------
  // Lock, input and holdover latches
  // --------------------------------------------------------------------------
  // A live bit at 0 is an event; it keeps setting its latch while it stays 0,
  // so a clear during an ongoing fault does not stick.
  assign src_event[3:0]               = ~live_s.input_active_live;          // [R10] [R14]
  assign src_event[`CSIU_BIT_OSC]     = ~live_s.osc_pll_lock_live_n;        // [R8] [R13]
  assign src_event[`CSIU_BIT_SYNTH]   = ~live_s.synth_pll_lock_live_n;      // [R7] [R13]
  assign src_event[`CSIU_SRC_HOLD]    = ~live_s.holdover_live_n;            // [R17]
  assign src_clear[5:0]               = wr_lat_lock ? reg_req.wdata[5:0] : 6'h00;  // [R9] [R11]
  assign src_clear[`CSIU_SRC_HOLD]    = wr_lat_ref && reg_req.wdata[`CSIU_BIT_HOLD]; // [R17]

  csiu_sticky #(
    .W (7)
  ) u_src_sticky (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .event_in (src_event),
    .clear_in (src_clear),
    .flag     (src_sticky)
  );

  // --------------------------------------------------------------------------
  // Reference latch and reference-change pending flag
  // --------------------------------------------------------------------------
  // The change flag catches both loss and return of the reference, so software
  // also hears when a lost reference comes back.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      ref_prev <= `CSIU_RST_REF_PREV;
    else
      ref_prev <= live_s.reference_present_live;
  end

  assign ref_edge     = ref_prev ^ live_s.reference_present_live;           // [R4]
  assign ref_event[0] = ~live_s.reference_present_live;                     // [R15] [R18]
  assign ref_event[1] = ref_edge;                                           // [R4]
  assign ref_clear    = {2{wr_lat_ref && reg_req.wdata[`CSIU_BIT_REF]}};    // [R16]

  csiu_sticky #(
    .W (2)
  ) u_ref_sticky (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .event_in (ref_event),
    .clear_in (ref_clear),
    .flag     (ref_sticky)
  );

  // --------------------------------------------------------------------------
  // Read views of the latches
  // --------------------------------------------------------------------------
  // Latches hold "event seen" internally and read inverted: 0 means an event.
  assign synth_pll_unlock_sticky_n_v = {2'b00, ~src_sticky[5:0]};            // [R7] [R8] [R10]
  assign reference_valid_sticky      = ~ref_sticky[0];                       // [R15]
  assign holdover_sticky_n           = ~src_sticky[`CSIU_SRC_HOLD];          // [R17]

  // --------------------------------------------------------------------------
  // Interrupt output
  // --------------------------------------------------------------------------
  // Registered so the pin never glitches while latches and enables change.
  assign next_irq_n = ~(|(src_sticky & src_irq_en)
                        | (ref_sticky[1] & reference_change_irq_en));       // [R1] [R2] [R3] [R4] [R5] [R19]

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      irq_out_n <= `CSIU_RST_IRQ_N;
    else
      irq_out_n <= next_irq_n;                                              // [R19]
  end

  // --------------------------------------------------------------------------
  // Read data multiplexer
  // --------------------------------------------------------------------------
  // Unmapped offsets and reserved bits read as zero.
  always_comb
  begin
    next_rdata = `CSIU_RST_RDATA;
    case (reg_req.addr)
      `CSIU_ADDR_IRQ_EN_LOCK:
        next_rdata = {2'b00, src_irq_en[5:0]};
      `CSIU_ADDR_IRQ_EN_REF:
        next_rdata = {6'h00, reference_change_irq_en, src_irq_en[`CSIU_SRC_HOLD]};
      `CSIU_ADDR_LATCHED_LOCK:
        next_rdata = synth_pll_unlock_sticky_n_v;                           // [R7] [R8] [R10]
      `CSIU_ADDR_LIVE_LOCK:
        next_rdata = {live_s.selected_input_code,                           // [R12]
                      live_s.synth_pll_lock_live_n,                         // [R13]
                      live_s.osc_pll_lock_live_n,                           // [R13]
                      live_s.input_active_live};                            // [R14]
      `CSIU_ADDR_LATCHED_REF:
        next_rdata = {6'h00, reference_valid_sticky, holdover_sticky_n};    // [R15] [R17]
      `CSIU_ADDR_LIVE_REF:
        next_rdata = {5'h00, live_s.synth_calibration_active,
                      live_s.reference_present_live,                        // [R18]
                      live_s.holdover_live_n};
      default:
        next_rdata = `CSIU_RST_RDATA;
    endcase
  end

  // Read data is captured on the read strobe and held until the next read.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      reg_rdata  <= `CSIU_RST_RDATA;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd)
        reg_rdata <= next_rdata;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  // A latched unlock with its enable held pulls the pin low one edge later.
  AST_SYNTH_IRQ: assert property ( // [R1]
    @(posedge sys_clk) disable iff (!rst_n)
    (src_sticky[`CSIU_BIT_SYNTH] && src_irq_en[`CSIU_BIT_SYNTH]) |=> !irq_out_n)
    else $error("synth unlock enabled but interrupt not asserted");

  AST_OSC_IRQ: assert property ( // [R2]
    @(posedge sys_clk) disable iff (!rst_n)
    (src_sticky[`CSIU_BIT_OSC] && src_irq_en[`CSIU_BIT_OSC]) |=> !irq_out_n)
    else $error("osc unlock enabled but interrupt not asserted");

  // A lost input seen after the synchroniser reaches the pin after the latch and output edges.
  AST_INPUT_IRQ: assert property ( // [R3]
    @(posedge sys_clk) disable iff (!rst_n)
    (!live_s.input_active_live[0] && src_irq_en[0]) ##1 src_irq_en[0] |=> !irq_out_n)
    else $error("input loss enabled but interrupt not asserted");

  // A return of the reference also raises the interrupt, not only its loss.
  AST_REF_RISE_IRQ: assert property ( // [R4]
    @(posedge sys_clk) disable iff (!rst_n)
    ($rose(live_s.reference_present_live) && reference_change_irq_en)
      ##1 reference_change_irq_en |=> !irq_out_n)
    else $error("reference change enabled but interrupt not asserted");

  AST_HOLD_IRQ: assert property ( // [R5]
    @(posedge sys_clk) disable iff (!rst_n)
    (!live_s.holdover_live_n && src_irq_en[`CSIU_SRC_HOLD])
      ##1 src_irq_en[`CSIU_SRC_HOLD] |=> !irq_out_n)
    else $error("holdover enabled but interrupt not asserted");

  // With every enable at zero the pin stays high whatever the latches hold.
  AST_MASKED_QUIET: assert property ( // [R6]
    @(posedge sys_clk) disable iff (!rst_n)
    (src_irq_en == 7'h00 && !reference_change_irq_en) |=> irq_out_n)
    else $error("interrupt asserted with all sources disabled");

  AST_ENABLE_RESET: assert property ( // [R6]
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> (src_irq_en == 7'h00 && !reference_change_irq_en))
    else $error("interrupt enables not zero after reset");

  // Once an unlock is seen the latch reads 0 until a write of 1 clears it.
  AST_SYNTH_LATCH: assert property ( // [R7]
    @(posedge sys_clk) disable iff (!rst_n)
    !live_s.synth_pll_lock_live_n |=> !synth_pll_unlock_sticky_n_v[`CSIU_BIT_SYNTH])
    else $error("synth unlock not latched");

  AST_OSC_HOLD_UNTIL_CLEAR: assert property ( // [R8]
    @(posedge sys_clk) disable iff (!rst_n)
    (src_sticky[`CSIU_BIT_OSC] && !(wr_lat_lock && reg_req.wdata[`CSIU_BIT_OSC]))
      |=> src_sticky[`CSIU_BIT_OSC])
    else $error("osc unlock latch dropped without a clear");

  AST_W1C_CLEARS: assert property ( // [R9]
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_lat_lock && reg_req.wdata[`CSIU_BIT_SYNTH] && live_s.synth_pll_lock_live_n)
      |=> !src_sticky[`CSIU_BIT_SYNTH] ##1 (irq_out_n || !next_irq_n))
    else $error("write one did not clear synth unlock latch");

  AST_REF_CLEAR: assert property ( // [R16]
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_lat_ref && reg_req.wdata[`CSIU_BIT_REF] && !ref_edge
      && live_s.reference_present_live) |=> (ref_sticky == 2'b00))
    else $error("write one did not clear reference latch");

  // The selection code read back is the one present at the read strobe.
  AST_SEL_READ: assert property ( // [R12]
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_req.rd && reg_req.addr == `CSIU_ADDR_LIVE_LOCK)
      |=> reg_rvalid && (reg_rdata[7:6] == $past(live_s.selected_input_code)))
    else $error("selection code read back wrong");

  AST_IRQ_RELEASE: assert property ( // [R19]
    @(posedge sys_clk) disable iff (!rst_n)
    (!irq_out_n && next_irq_n) |=> irq_out_n)
    else $error("interrupt held after every source cleared");

  // Each fault kind is checked on one representative bit to keep the list short.
  AST_OSC_LATCH: assert property ( // [R8]
    @(posedge sys_clk) disable iff (!rst_n)
    !live_s.osc_pll_lock_live_n |=> !synth_pll_unlock_sticky_n_v[`CSIU_BIT_OSC])
    else $error("osc unlock not latched");

  AST_INPUT_LATCH: assert property ( // [R10]
    @(posedge sys_clk) disable iff (!rst_n)
    !live_s.input_active_live[3] |=> !synth_pll_unlock_sticky_n_v[3])
    else $error("input loss not latched");

  // A clear only sticks when the fault is gone in the clearing cycle.
  AST_INPUT_CLEAR: assert property ( // [R11]
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_lat_lock && reg_req.wdata[1] && live_s.input_active_live[1]) |=> !src_sticky[1])
    else $error("input latch not cleared");

  AST_HOLD_CLEAR: assert property ( // [R17]
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_lat_ref && reg_req.wdata[`CSIU_BIT_HOLD] && live_s.holdover_live_n) |=> holdover_sticky_n)
    else $error("holdover latch not cleared");

  AST_REF_LOST_LATCH: assert property ( // [R15]
    @(posedge sys_clk) disable iff (!rst_n)
    !live_s.reference_present_live |=> !reference_valid_sticky)
    else $error("reference loss not latched");

  // Loss of the reference interrupts as well as its return.
  AST_REF_FALL_IRQ: assert property ( // [R4]
    @(posedge sys_clk) disable iff (!rst_n)
    ($fell(live_s.reference_present_live) && reference_change_irq_en)
      ##1 reference_change_irq_en |=> !irq_out_n)
    else $error("reference loss did not interrupt");

  // Live bits read back as they stood at the read strobe.
  AST_ACTIVE_READ: assert property ( // [R14]
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_req.rd && reg_req.addr == `CSIU_ADDR_LIVE_LOCK)
      |=> (reg_rdata[3:0] == $past(live_s.input_active_live)))
    else $error("input activity read back wrong");

  AST_REF_LIVE_READ: assert property ( // [R18]
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_req.rd && reg_req.addr == `CSIU_ADDR_LIVE_REF)
      |=> (reg_rdata[`CSIU_BIT_REF] == $past(live_s.reference_present_live)))
    else $error("reference presence read back wrong");

  // Nothing enabled and pending means the pin is high one edge later.
  AST_IRQ_QUIET: assert property ( // [R6] [R19]
    @(posedge sys_clk) disable iff (!rst_n)
    (!(|(src_sticky & src_irq_en)) && !(ref_sticky[1] && reference_change_irq_en)) |=> irq_out_n)
    else $error("interrupt with no enabled source pending");

endmodule : csiu_top
`default_nettype wire

// File: csiu_host_model.sv
// Host controller model: issues register reads and writes on reg_req.
// Assumes one bench process calls its tasks, all timed on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module csiu_host_model
  import csiu_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic [7:0]    reg_rdata,
  input  wire logic          reg_rvalid,
  output var  csiu_reg_req_t reg_req
);
  // Quiet bus at time zero.
  initial reg_req = '{rd: 1'b0, wr: 1'b0, addr: 8'h00, wdata: 8'h00};

  // One-cycle request. When idle, the address and data carry the inverse of
  // the last value, so stale fields cannot pass for a live request.
  task automatic access(input logic rd, input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_req <= '{rd: rd, wr: wr, addr: a, wdata: d};
    @(posedge sys_clk);
    reg_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask : access

  // Writing ones acknowledges latched events.
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    access(1'b0, 1'b1, a, d);
  endtask : write

  // The answer stands after the taking edge and is sampled at the next one.
  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
    access(1'b1, 1'b0, a, 8'h00);
    @(posedge sys_clk);
    ok = reg_rvalid;
    d  = reg_rdata;
  endtask : read
endmodule : csiu_host_model
`default_nettype wire

// File: clock_status_interrupt_unit_tb.sv
// Self-checking bench for csiu_top, with a model built from bit vectors.
// Assumes csiu_host_model drives the register port.
`timescale 1ns/1ps
`default_nettype none
module clock_status_interrupt_unit_tb
  import csiu_pkg::*;
;
  logic          sys_clk     = 1'b0;
  logic          rst_n       = 1'b0;
  csiu_live_t    live_in     = 11'h1fe;
  csiu_reg_req_t reg_req;
  logic [7:0]    reg_rdata;
  logic          reg_rvalid;
  logic          irq_out_n;
  int            n_errors    = 0;
  int            checks_done = 0;
  int            cycles      = 0;
  // Model: event flags (1 = event seen), enables and current live value.
  logic [5:0]    ev_lock     = '0;
  logic [5:0]    en_lock     = '0;
  logic [1:0]    en_rh       = '0;
  logic          ref_lost    = 1'b0;
  logic          ref_pend    = 1'b0;
  logic          hold_ev     = 1'b0;
  csiu_live_t    cur         = 11'h1fe;

  csiu_top dut (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .live_in    (live_in),
    .reg_req    (reg_req),
    .reg_rdata  (reg_rdata),
    .reg_rvalid (reg_rvalid),
    .irq_out_n  (irq_out_n)
  );

  csiu_host_model host (
    .sys_clk    (sys_clk),
    .reg_rdata  (reg_rdata),
    .reg_rvalid (reg_rvalid),
    .reg_req    (reg_req)
  );

  // --------------------------------------------------------------------------
  // Clock and hang guard
  // --------------------------------------------------------------------------
  always #20 sys_clk = ~sys_clk;

  // The whole run needs under two thousand cycles; the ceiling leaves ample margin.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      finish_test();
    end
  end

  // --------------------------------------------------------------------------
  // Checking tasks
  // --------------------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    host.read(a, d, ok);
    cmp("read strobe", 8'h01, {7'h00, ok});
    cmp($sformatf("register %h", a), e, d);
  endtask : rd_chk

  // Reads every register and an unmapped one, then the interrupt line.
  task automatic check_all();
    logic irq;
    irq = ~(|(ev_lock & en_lock) | (en_rh[1] & ref_pend) | (en_rh[0] & hold_ev));
    rd_chk(8'h68, {2'b00, en_lock});
    rd_chk(8'h69, {6'h00, en_rh});
    rd_chk(8'h6c, {2'b00, ~ev_lock});
    rd_chk(8'h6d, cur[10:3]);
    rd_chk(8'h6e, {6'h00, ~ref_lost, ~hold_ev});
    rd_chk(8'h6f, {5'h00, cur[0], cur[2], cur[1]});
    rd_chk(8'h00, 8'h00);
    cmp("irq_out_n", {7'h00, irq}, {7'h00, irq_out_n});
  endtask : check_all

  // Live levels need two sync edges, one latch edge and one output edge.
  task automatic apply_live(input csiu_live_t v);
    @(posedge sys_clk);
    live_in <= v;
    repeat (6) @(posedge sys_clk);
    ev_lock |= ~v[8:3];
    ref_pend |= v[2] ^ cur[2];
    ref_lost |= ~v[2];
    hold_ev |= ~v[1];
    cur = v;
  endtask : apply_live

  // A fault that persists re-sets its latch, so a clear cannot hide it.
  task automatic wr_m(input logic [7:0] a, input logic [7:0] d);
    host.write(a, d);
    repeat (2) @(posedge sys_clk);
    case (a)
      8'h68: en_lock = d[5:0];
      8'h69: en_rh = d[1:0];
      8'h6c: ev_lock = (ev_lock & ~d[5:0]) | ~cur[8:3];
      8'h6e:
      begin
        ref_pend &= ~d[1];
        ref_lost = d[1] ? ~cur[2] : ref_lost;
        hold_ev = d[0] ? ~cur[1] : hold_ev;
      end
      default: ;
    endcase
  endtask : wr_m

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    csiu_live_t v;
    void'($urandom(32'h7babe88a));
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    check_all();
    $display("test reset done");
    repeat (4)
    begin
      wr_m(8'h68, 8'($urandom));
      wr_m(8'h69, 8'($urandom));
      check_all();
    end
    $display("test enables done");
    for (int i = 0; i < 6; i++)
    begin
      wr_m(8'h68, 8'h00);
      v = 11'h1fe;
      v[3 + i] = 1'b0;
      apply_live(v);
      check_all();
      wr_m(8'h68, 8'h01 << i);
      check_all();
      wr_m(8'h6c, 8'h01 << i);
      check_all();
      apply_live(11'h1fe);
      wr_m(8'h6c, 8'h01 << i);
      check_all();
    end
    $display("test lock and input sources done");
    for (int s = 0; s < 4; s++)
    begin
      v = 11'h1fe;
      v[10:9] = 2'(s);
      v[0] = 1'($urandom);
      apply_live(v);
      check_all();
    end
    $display("test selection done");
    wr_m(8'h69, 8'h02);
    apply_live(11'h1fa);
    check_all();
    apply_live(11'h1fe);
    check_all();
    wr_m(8'h6e, 8'h02);
    check_all();
    wr_m(8'h69, 8'h01);
    apply_live(11'h1fc);
    check_all();
    apply_live(11'h1fe);
    wr_m(8'h6e, 8'h01);
    check_all();
    $display("test reference and holdover done");
    repeat (12)
    begin
      apply_live(11'($urandom));
      wr_m(8'h68, 8'($urandom));
      wr_m(8'h69, 8'($urandom));
      wr_m(8'h6c, 8'($urandom));
      wr_m(8'h6e, 8'($urandom));
      check_all();
    end
    $display("test random traffic done");
    apply_live(11'h000);
    wr_m(8'h68, 8'h3f);
    wr_m(8'h69, 8'h03);
    wr_m(8'h6d, 8'hff);
    wr_m(8'h6f, 8'hff);
    wr_m(8'h00, 8'hff);
    check_all();
    wr_m(8'h68, 8'h00);
    wr_m(8'h69, 8'h00);
    check_all();
    $display("test disable done");
    finish_test();
  end
endmodule : clock_status_interrupt_unit_tb
`default_nettype wire
